// [shared/network_input_bit_map_defs.svh]
// Constants for the network input function mapper.
// Assumes inclusion by bare name from the package and the design files.
`ifndef NETWORK_INPUT_BIT_MAP_DEFS_SVH
`define NETWORK_INPUT_BIT_MAP_DEFS_SVH

`define NIM_BITS 16
`define NIM_CODE_W 8
`define NIM_DIRECT_BITS 7
`define NIM_CODE_NONE 8'h00
`define NIM_CODE_FORWARD 8'h01
`define NIM_CODE_REVERSE 8'h02
`define NIM_CODE_STOP 8'h13
`define NIM_CODE_BRAKE 8'h14
`define NIM_CODE_PANEL 8'h1B
`define NIM_CODE_FLAG0 8'h20
`define NIM_CODE_FLAG15 8'h2F
`define NIM_CODE_OPSEL0 8'h30
`define NIM_CODE_OPSEL3 8'h33
`define NIM_CODE_TORQUE 8'h36
// Reset selects for bits 0..6; higher bits reset to code zero
`define NIM_RST_SEL0 8'h30
`define NIM_RST_SEL1 8'h31
`define NIM_RST_SEL2 8'h32
`define NIM_RST_SEL3 8'h01
`define NIM_RST_SEL4 8'h02
`define NIM_RST_SEL5 8'h13
`define NIM_RST_SEL6 8'h14

`endif

// [shared/network_input_bit_map_pkg.sv]
// Types for the network input function mapper.
// Assumes the constants header sits beside it.
`include "network_input_bit_map_defs.svh"

package network_input_bit_map_pkg;
    typedef logic [`NIM_CODE_W-1:0] func_code_t;

    // Decoded internal control functions
    typedef struct packed {
        logic forward_run;
        logic reverse_run;
        logic stop_decel;
        logic brake_release;
        logic panel_limit_release;
        logic [15:0] general_flag;
        logic [3:0] op_data_select_bit;
        logic torque_limit_enable;
    } func_out_t;

    // Direct terminal view of the normally-closed functions
    typedef struct packed {
        logic panel_assigned;
        logic panel_all_on;
        logic torque_assigned;
        logic torque_all_on;
    } nc_direct_t;
endpackage

// [design/network_input_bit_select_decode.sv]
// Per-position match of all sixteen selects against a single function code.
// Assumes selects and input bits come from flip-flops in the same clock domain.
`timescale 1ns/1ps
`include "network_input_bit_map_defs.svh"

module network_input_bit_select_decode #(
    parameter int NBITS = `NIM_BITS
) (
    // Selects and data
    input wire logic [NBITS*`NIM_CODE_W-1:0] sel_flat,
    input wire logic [NBITS-1:0] bits_in,
    input wire logic [`NIM_CODE_W-1:0] code,
    // Results
    output logic any_on,
    output logic all_on,
    output logic assigned
);
    logic [NBITS-1:0] hit;

    // Match each position; code zero never matches a function
    genvar g;
    generate
        for (g = 0; g < NBITS; g++) begin : g_hit
            assign hit[g] = (sel_flat[g*`NIM_CODE_W +: `NIM_CODE_W] == code);
        end
    endgenerate

    // Combine duplicates
    assign assigned = |hit;
    assign any_on = |(hit & bits_in);
    assign all_on = &(~hit | bits_in);
endmodule // network_input_bit_select_decode

// [design/network_input_function_mapper.sv]
// Network input function mapper: sixteen host-written bits onto internal functions.
// Assumes bit and select writes arrive synchronous to ref_clk from the link handler.
`timescale 1ns/1ps
`include "network_input_bit_map_defs.svh"

module network_input_function_mapper
    import network_input_bit_map_pkg::*;
#(
    parameter int NBITS = `NIM_BITS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Network input bits from the host
    input wire logic [NBITS-1:0] network_input_bit,
    // Function-select write port
    input wire logic sel_wr,
    input wire logic [3:0] sel_idx,
    input wire network_input_bit_map_pkg::func_code_t sel_code,
    // Direct terminal contribution to normally-closed functions
    input wire network_input_bit_map_pkg::nc_direct_t nc_direct,
    // Select readback and decoded functions
    output logic [NBITS*`NIM_CODE_W-1:0] sel_readback,
    output network_input_bit_map_pkg::func_out_t func_out
);
    import network_input_bit_map_pkg::*;

    // Elaboration check: index port serves exactly sixteen positions
    if (NBITS != 16) begin : g_bad_nbits
        $error("NBITS must be 16");
    end

    logic rst_meta_r;
    logic rst_sync_r;
    logic [NBITS*`NIM_CODE_W-1:0] sel_r;
    logic [NBITS-1:0] bits_r;
    func_out_t func_nxt;
    func_out_t func_r;

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Function-select table, one code per position
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sel_r <= '0;
            sel_r[0*`NIM_CODE_W +: `NIM_CODE_W] <= `NIM_RST_SEL0;
            sel_r[1*`NIM_CODE_W +: `NIM_CODE_W] <= `NIM_RST_SEL1;
            sel_r[2*`NIM_CODE_W +: `NIM_CODE_W] <= `NIM_RST_SEL2;
            sel_r[3*`NIM_CODE_W +: `NIM_CODE_W] <= `NIM_RST_SEL3;
            sel_r[4*`NIM_CODE_W +: `NIM_CODE_W] <= `NIM_RST_SEL4;
            sel_r[5*`NIM_CODE_W +: `NIM_CODE_W] <= `NIM_RST_SEL5;
            sel_r[6*`NIM_CODE_W +: `NIM_CODE_W] <= `NIM_RST_SEL6;
        end else if (sel_wr) begin
            sel_r[sel_idx*`NIM_CODE_W +: `NIM_CODE_W] <= sel_code;
        end
    end

    // Capture of host bits
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            bits_r <= '0;
        end else begin
            bits_r <= network_input_bit;
        end
    end

    // Decoders: fixed functions, flags and select bits
    localparam int NFUNC = 26;
    localparam logic [NFUNC*`NIM_CODE_W-1:0] CODES = {
        `NIM_CODE_TORQUE, `NIM_CODE_PANEL,
        8'h33, 8'h32, 8'h31, `NIM_CODE_OPSEL0,
        `NIM_CODE_FLAG15, 8'h2E, 8'h2D, 8'h2C, 8'h2B, 8'h2A, 8'h29, 8'h28,
        8'h27, 8'h26, 8'h25, 8'h24, 8'h23, 8'h22, 8'h21, `NIM_CODE_FLAG0,
        `NIM_CODE_BRAKE, `NIM_CODE_STOP, `NIM_CODE_REVERSE, `NIM_CODE_FORWARD};
    logic [NFUNC-1:0] any_on;
    logic [NFUNC-1:0] all_on;
    logic [NFUNC-1:0] assigned;

    genvar f;
    generate
        for (f = 0; f < NFUNC; f++) begin : g_func
            network_input_bit_select_decode #(.NBITS(NBITS)) u_dec (
                .sel_flat(sel_r),
                .bits_in(bits_r),
                .code(CODES[f*`NIM_CODE_W +: `NIM_CODE_W]),
                .any_on(any_on[f]),
                .all_on(all_on[f]),
                .assigned(assigned[f])
            );
        end
    endgenerate

    // Combine into functions; unassigned normally-open ones fall to 0 via any_on
    always_comb begin
        func_nxt.forward_run = any_on[0];
        func_nxt.reverse_run = any_on[1];
        func_nxt.stop_decel = any_on[2];
        func_nxt.brake_release = any_on[3];
        func_nxt.general_flag = any_on[19:4];
        func_nxt.op_data_select_bit = any_on[23:20];
        // Normally closed: on when unassigned everywhere, else all must be on
        func_nxt.panel_limit_release = all_on[24] &
            (!nc_direct.panel_assigned | nc_direct.panel_all_on);
        func_nxt.torque_limit_enable = all_on[25] &
            (!nc_direct.torque_assigned | nc_direct.torque_all_on);
    end

    // Registered function outputs; normally-closed ones reset on
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            func_r <= '0;
            func_r.panel_limit_release <= 1'b1;
            func_r.torque_limit_enable <= 1'b1;
        end else begin
            func_r <= func_nxt;
        end
    end

    assign func_out = func_r;
    assign sel_readback = sel_r;

    // Forward run follows its mapped bit two cycles later
    a_forward_follow: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (sel_r[3*`NIM_CODE_W +: `NIM_CODE_W] == `NIM_CODE_FORWARD && $stable(sel_r)
         && network_input_bit[3]) ##1 $stable(sel_r) |=> func_out.forward_run)
        else $error("forward run not driven by mapped bit");

    // Unassigned torque limit with no direct terminal stays on
    a_torque_default_on: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (!assigned[25] && !nc_direct.torque_assigned) |=> func_out.torque_limit_enable)
        else $error("unassigned torque limit not on");

    // Panel release off whenever an assigned net bit is off
    a_panel_all_on: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (assigned[24] && !all_on[24]) |=> !func_out.panel_limit_release)
        else $error("panel release on with an assigned bit off");

    // Unassigned reverse run stays low
    a_reverse_idle: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        !assigned[1] |=> !func_out.reverse_run)
        else $error("unassigned reverse run active");

    // Any duplicate active drives the flag
    a_flag_any: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (any_on[4] && assigned[4]) |=> func_out.general_flag[0])
        else $error("general flag 0 missed an active bit");

    // Stop select reflects its code
    a_stop_map: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        !any_on[2] |=> !func_out.stop_decel)
        else $error("stop select set without active bit");

    // Brake release follows
    a_brake_map: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        any_on[3] |=> func_out.brake_release)
        else $error("brake release not driven");

    // Operation data select reflects its bits
    a_opsel_map: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        1'b1 |=> func_out.op_data_select_bit == $past(any_on[23:20]))
        else $error("op data select mismatch");

    // Reset selects: bit 3 forward after release
    a_rst_sel: assert property (
        @(posedge ref_clk)
        $rose(rst_sync_r) |-> sel_r[3*`NIM_CODE_W +: `NIM_CODE_W] == `NIM_CODE_FORWARD)
        else $error("reset select wrong");

    // Torque limit off whenever its direct terminal is off
    a_torque_nc: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (nc_direct.torque_assigned && !nc_direct.torque_all_on) |=>
        !func_out.torque_limit_enable)
        else $error("torque limit on with direct terminal off");

    // Panel release on with all assigned on
    a_panel_map: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (all_on[24] && !nc_direct.panel_assigned) |=> func_out.panel_limit_release)
        else $error("panel release not on");

    // Write takes effect next cycle
    a_sel_write: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        sel_wr |=> sel_r[$past(sel_idx)*`NIM_CODE_W +: `NIM_CODE_W] == $past(sel_code))
        else $error("select write lost");

    // Unassigned panel release with no direct terminal stays on
    a_panel_default_on: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (!assigned[24] && !nc_direct.panel_assigned) |=> func_out.panel_limit_release)
        else $error("unassigned panel release not on");

    // Unassigned forward run stays low
    a_forward_idle: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        !assigned[0] |=> !func_out.forward_run)
        else $error("unassigned forward run active");

    // Reverse run follows any active mapped bit
    a_reverse_follow: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        any_on[1] |=> func_out.reverse_run)
        else $error("reverse run not driven");

    // Torque limit off whenever an assigned net bit is off
    a_torque_net_off: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (assigned[25] && !all_on[25]) |=> !func_out.torque_limit_enable)
        else $error("torque limit on with an assigned bit off");

    // Panel release off whenever its direct terminal is off
    a_panel_direct_off: assert property (
        @(posedge ref_clk) disable iff (!rst_sync_r)
        (nc_direct.panel_assigned && !nc_direct.panel_all_on) |=>
        !func_out.panel_limit_release)
        else $error("panel release on with direct terminal off");
endmodule // network_input_function_mapper

// [verif/host_model.sv]
// Host controller model: writes function selects and network input bits.
// Assumes the bench calls its tasks; every change lands at the falling edge.
`timescale 1ns/1ps

module host_model
    import network_input_bit_map_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Toward the mapper
    output logic [15:0] network_input_bit,
    output logic sel_wr,
    output logic [3:0] sel_idx,
    output network_input_bit_map_pkg::func_code_t sel_code
);
    // Idle values at time zero
    initial begin
        network_input_bit = 16'h0000;
        sel_wr = 1'b0;
        sel_idx = 4'hF;
        sel_code = 8'hFF;
    end

    // One select write; consecutive calls give back-to-back strobes
    task automatic write_sel(input logic [3:0] idx, input func_code_t code);
        @(negedge ref_clk);
        sel_wr = 1'b1;
        sel_idx = idx;
        sel_code = code;
    endtask

    // Drop the strobe; idle fields are scrambled so stale values never help
    task automatic end_writes();
        @(negedge ref_clk);
        sel_wr = 1'b0;
        sel_idx = ~sel_idx;
        sel_code = ~sel_code;
    endtask

    // New bit pattern; duplicate selects only when the bench asks for them
    task automatic set_bits(input logic [15:0] b);
        @(negedge ref_clk);
        network_input_bit = b;
    endtask
endmodule // host_model

// [verif/tb_top.sv]
// Self-checking bench for the network input function mapper.
// Assumes the host model drives the mapper's host-side ports.
`timescale 1ns/1ps
`include "network_input_bit_map_defs.svh"

module tb_top;
    import network_input_bit_map_pkg::*;
    logic ref_clk;
    logic nrst;
    nc_direct_t nc_direct;
    logic [15:0] network_input_bit;
    logic sel_wr;
    logic [3:0] sel_idx;
    func_code_t sel_code;
    logic [127:0] sel_readback;
    logic [127:0] exp_sel;
    func_out_t func_out;
    func_out_t e;
    int n_errors;
    int num_checks;

    // Clock at 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    host_model host_u (.ref_clk(ref_clk), .network_input_bit(network_input_bit),
        .sel_wr(sel_wr), .sel_idx(sel_idx), .sel_code(sel_code));

    network_input_function_mapper dut_u (.ref_clk(ref_clk), .nrst(nrst),
        .network_input_bit(network_input_bit), .sel_wr(sel_wr), .sel_idx(sel_idx),
        .sel_code(sel_code), .nc_direct(nc_direct), .sel_readback(sel_readback),
        .func_out(func_out));

    // Compare and count
    task automatic check(input string name, input logic [127:0] seen,
                         input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // Wait past the output latency, then compare func_out
    task automatic expect_out();
        repeat (4) @(negedge ref_clk);
        check("func_out", func_out, e);
    endtask

    // Outputs with nothing assigned: only the normally-closed ones on
    function automatic func_out_t idle_out();
        func_out_t f;
        f = '0;
        f.panel_limit_release = 1'b1;
        f.torque_limit_enable = 1'b1;
        return f;
    endfunction

    // One normally-closed case: bits, direct panel level, expected levels
    task automatic nc_case(input logic [15:0] b, input logic pall, input logic ep,
                           input logic et);
        @(negedge ref_clk);
        nc_direct.panel_all_on = pall;
        host_u.set_bits(b);
        e.panel_limit_release = ep;
        e.torque_limit_enable = et;
        expect_out();
    endtask

    task automatic stop_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        n_errors = 0;
        num_checks = 0;
        nrst = 1'b0;
        nc_direct = '0;
        repeat (8) @(negedge ref_clk);
        e = idle_out();
        check("sel_readback", sel_readback,
              {72'h0, 8'h14, 8'h13, 8'h02, 8'h01, 8'h32, 8'h31, 8'h30});
        check("func_out", func_out, e);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        // Default map, every bit high
        host_u.set_bits(16'hFFFF);
        e.forward_run = 1'b1;
        e.reverse_run = 1'b1;
        e.stop_decel = 1'b1;
        e.brake_release = 1'b1;
        e.op_data_select_bit = 4'h7;
        expect_out();
        // All positions to general flags, back to back
        for (int i = 0; i < 16; i++) begin
            host_u.write_sel(i[3:0], 8'h20 + i[7:0]);
            exp_sel[8*i+:8] = 8'h20 + i[7:0];
        end
        host_u.end_writes();
        host_u.set_bits(16'hA5C3);
        e = idle_out();
        e.general_flag = 16'hA5C3;
        expect_out();
        check("sel_readback", sel_readback, exp_sel);
        // Selector bits, duplicate forward run, unknown code, unused code
        for (int i = 0; i < 4; i++) begin
            host_u.write_sel(i[3:0], 8'h30 + i[7:0]);
        end
        host_u.write_sel(4'h4, 8'h01);
        host_u.write_sel(4'h5, 8'h01);
        host_u.write_sel(4'h6, 8'h03);
        host_u.write_sel(4'h7, 8'h00);
        host_u.end_writes();
        host_u.set_bits(16'h00EA);
        e = idle_out();
        e.op_data_select_bit = 4'hA;
        e.forward_run = 1'b1;
        expect_out();
        host_u.set_bits(16'h00CA);
        e.forward_run = 1'b0;
        expect_out();
        // Normally-closed functions on network and direct terminals
        host_u.write_sel(4'h8, 8'h1B);
        host_u.write_sel(4'h9, 8'h1B);
        host_u.write_sel(4'hA, 8'h36);
        host_u.end_writes();
        nc_direct.panel_assigned = 1'b1;
        e.op_data_select_bit = 4'h0;
        nc_case(16'h0700, 1'b1, 1'b1, 1'b1);
        nc_case(16'h0500, 1'b1, 1'b0, 1'b1);
        nc_case(16'h0700, 1'b0, 1'b0, 1'b1);
        nc_case(16'h0300, 1'b1, 1'b1, 1'b0);
        // Drop network assignments; direct torque assigned and off
        for (int i = 8; i < 11; i++) begin
            host_u.write_sel(i[3:0], 8'h00);
        end
        host_u.end_writes();
        nc_direct.panel_assigned = 1'b0;
        nc_direct.torque_assigned = 1'b1;
        nc_case(16'h0000, 1'b0, 1'b1, 1'b0);
        // Direct torque terminal on alone turns torque limit back on
        nc_direct.torque_all_on = 1'b1;
        nc_case(16'h0000, 1'b0, 1'b1, 1'b1);
        stop_test();
    end
endmodule // tb_top
